/* File: dual_port_pin_io_defs.svh */
// Register offsets, reset values and field positions for the dual port block.
`ifndef DUAL_PORT_PIN_IO_DEFS_SVH
`define DUAL_PORT_PIN_IO_DEFS_SVH
`define OFS_PORT9_OUTPUT_DATA 16'hffdc
`define OFS_PORTB_PIN_LEVELS 16'hffdd
`define OFS_PORT9_DIRECTION_CONTROL 16'hffec
`define OFS_CONVERTER_MODE_REGISTER 16'hffc4
`define RST_PORT9_OUTPUT_DATA 8'hc0
`define RST_PORT9_DIRECTION_CONTROL 8'hc0
`define RST_CONVERTER_MODE_REGISTER 8'h00
`define PORT9_FIXED_HIGH 8'hc0
`define PORT9_PIN_MASK 8'h1f
`define WO_READ_VALUE 8'hff
`define UNMAPPED_READ_VALUE 8'h00
`define CONV_CHAN_LSB 0
`define CONV_CHAN_BIT_ON 3
`define CONV_CHAN_WIDTH 4
`endif

/* File: dual_port_pin_io_pkg.sv */
// Types shared by the dual port block.
package dual_port_pin_io_pkg;
   typedef enum logic [2:0] {
      MODE_ACTIVE,
      MODE_SUBACTIVE,
      MODE_SLEEP,
      MODE_SUBSLEEP,
      MODE_WATCH,
      MODE_STANDBY
   } power_mode_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
   typedef struct packed {
      logic [4:0] out;
      logic [4:0] oe;
   } port9_drive_t;
endpackage : dual_port_pin_io_pkg

/* File: dual_port_pin_io.sv */
// Five-pin bidirectional port nine and eight-pin input-only port B.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "dual_port_pin_io_defs.svh"
module dual_port_pin_io
   import dual_port_pin_io_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire power_mode_t power_mode,
   input wire logic [4:0] port9_pin_in,
   output logic [4:0] port9_pin_out,
   output logic [4:0] port9_pin_oe,
   input wire logic [7:0] portb_pin_in,
   output logic [7:0] analog_input_pin_sel
);
   reg_req_t req;
   port9_drive_t drive_d;
   logic [4:0] p9_meta_q, p9_sync_q;
   logic [7:0] pb_meta_q, pb_sync_q;
   logic [7:0] port9_output_data_q;
   logic [7:0] port9_direction_control_q;
   logic [7:0] converter_mode_register_q;
   logic [4:0] port9_pin_out_q, port9_pin_oe_q;
   logic [7:0] reg_rdata_q, analog_sel_q, analog_sel_d;
   logic [7:0] rdata_d, port9_read, portb_read;
   logic [3:0] chan;
   logic chan_on;
   logic [4:0] dir;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign dir = port9_direction_control_q[4:0];
   assign chan = converter_mode_register_q[`CONV_CHAN_LSB +:
                                           `CONV_CHAN_WIDTH];
   assign chan_on = chan[`CONV_CHAN_BIT_ON];

   // Pins come from the board, so each passes two flops before use.
   always_ff @(posedge clk_sys) begin
      p9_meta_q <= port9_pin_in;
      p9_sync_q <= p9_meta_q;
      pb_meta_q <= portb_pin_in;
      pb_sync_q <= pb_meta_q;
   end

   // Bits 7 to 5 are fixed, so only the pin bits are ever stored.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         port9_output_data_q <= `RST_PORT9_OUTPUT_DATA;
      end else if (req.wr && req.addr == `OFS_PORT9_OUTPUT_DATA) begin
         port9_output_data_q <= `PORT9_FIXED_HIGH |
            (req.wdata & `PORT9_PIN_MASK);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         port9_direction_control_q <= `RST_PORT9_DIRECTION_CONTROL;
      end else if (req.wr && req.addr == `OFS_PORT9_DIRECTION_CONTROL) begin
         port9_direction_control_q <= `PORT9_FIXED_HIGH |
            (req.wdata & `PORT9_PIN_MASK);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         converter_mode_register_q <= `RST_CONVERTER_MODE_REGISTER;
      end else if (req.wr && req.addr == `OFS_CONVERTER_MODE_REGISTER) begin
         converter_mode_register_q <= req.wdata;
      end
   end

   // Drivers are flopped again after the registers, so in active and subactive modes a write shows two clocks later.
   always_comb begin
      drive_d.out = port9_output_data_q[4:0];
      drive_d.oe = dir;
      unique case (power_mode)
         MODE_ACTIVE, MODE_SUBACTIVE: begin
         end
         MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH: begin
            drive_d.out = port9_pin_out_q;
            drive_d.oe = port9_pin_oe_q;
         end
         MODE_STANDBY: begin
            drive_d.oe = '0;
         end
         default: begin
            drive_d.oe = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         port9_pin_out_q <= '0;
         port9_pin_oe_q <= '0;
      end else begin
         port9_pin_out_q <= drive_d.out;
         port9_pin_oe_q <= drive_d.oe;
      end
   end

   // Port B has no driver at all; only the channel mask reaches it.
   always_comb begin
      analog_sel_d = '0;
      if (chan_on) begin
         analog_sel_d[chan[2:0]] = 1'b1;
      end
      portb_read = pb_sync_q & ~analog_sel_d;
      port9_read = `PORT9_FIXED_HIGH |
         {3'h0, (dir & port9_output_data_q[4:0]) |
                (~dir & p9_sync_q)};
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         analog_sel_q <= '0;
      end else begin
         analog_sel_q <= analog_sel_d;
      end
   end

   always_comb begin
      unique case (req.addr)
         `OFS_PORT9_OUTPUT_DATA: rdata_d = port9_read;
         `OFS_PORTB_PIN_LEVELS: rdata_d = portb_read;
         `OFS_PORT9_DIRECTION_CONTROL: rdata_d = `WO_READ_VALUE;
         `OFS_CONVERTER_MODE_REGISTER: rdata_d = converter_mode_register_q;
         default: rdata_d = `UNMAPPED_READ_VALUE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata_q <= '0;
      end else if (req.rd) begin
         reg_rdata_q <= rdata_d;
      end else begin
         reg_rdata_q <= '0;
      end
   end

   assign reg_rdata = reg_rdata_q;
   assign port9_pin_out = port9_pin_out_q;
   assign port9_pin_oe = port9_pin_oe_q;
   assign analog_input_pin_sel = analog_sel_q;

   a_dir_reset_value: assert property (@(posedge clk_sys)
      $past(reset) |-> port9_direction_control_q == 8'hc0)
      else $error("direction register not c0 after reset");
   a_dir_read_ones: assert property (@(posedge clk_sys) disable iff (reset)
      reg_rd && reg_addr == 16'hffec |=> reg_rdata == 8'hff)
      else $error("direction register read not all ones");
   a_oe_follows_dir: assert property (@(posedge clk_sys) disable iff (reset)
      power_mode == MODE_ACTIVE |=> port9_pin_oe == $past(dir))
      else $error("output enable does not follow direction");
   a_out_write_lag: assert property (@(posedge clk_sys) disable iff (reset)
      reg_wr && reg_addr == 16'hffdc && power_mode == MODE_ACTIVE
      ##1 power_mode == MODE_ACTIVE
      |=> port9_pin_out == $past(reg_wdata[4:0], 2))
      else $error("output pin not driven from written data");
   a_standby_float: assert property (@(posedge clk_sys)
      reset || power_mode == MODE_STANDBY |=> port9_pin_oe == 5'h00)
      else $error("port nine driven in reset or standby");
   a_sleep_hold: assert property (@(posedge clk_sys) disable iff (reset)
      power_mode == MODE_SLEEP || power_mode == MODE_WATCH
      |=> $stable(port9_pin_out) && $stable(port9_pin_oe))
      else $error("port nine changed while held");
   a_fixed_bits: assert property (@(posedge clk_sys) disable iff (reset)
      reg_rd && reg_addr == 16'hffdc |=> reg_rdata[7:5] == 3'b110)
      else $error("port nine fixed bits wrong");
   a_analog_zero: assert property (@(posedge clk_sys) disable iff (reset)
      reg_rd && reg_addr == 16'hffdd
      |=> (reg_rdata & analog_sel_q) == 8'h00)
      else $error("selected analog pin does not read 0");
   a_input_level: assert property (@(posedge clk_sys) disable iff (reset)
      reg_rd && reg_addr == 16'hffdc && dir == 5'h00
      |=> reg_rdata[4:0] == $past(p9_sync_q))
      else $error("input pin level not read");

   a_rdata_idle: assert property (@(posedge clk_sys) disable iff (reset)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");

   a_unmapped_zero: assert property (@(posedge clk_sys)
      disable iff (reset)
      reg_rd && reg_addr != 16'hffdc && reg_addr != 16'hffdd &&
      reg_addr != 16'hffec && reg_addr != 16'hffc4
      |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   a_read_no_effect: assert property (@(posedge clk_sys)
      disable iff (reset)
      reg_rd && !reg_wr
      |=> $stable(port9_direction_control_q) &&
          $stable(port9_output_data_q) &&
          $stable(converter_mode_register_q))
      else $error("read changed a register");

   a_dir_write: assert property (@(posedge clk_sys) disable iff (reset)
      reg_wr && reg_addr == 16'hffec |=> dir == $past(reg_wdata[4:0]))
      else $error("direction write not stored");

   a_dir_fixed: assert property (@(posedge clk_sys) disable iff (reset)
      port9_direction_control_q[7:5] == 3'b110)
      else $error("direction fixed bits wrong");

   a_data_fixed: assert property (@(posedge clk_sys) disable iff (reset)
      port9_output_data_q[7:5] == 3'b110)
      else $error("output data fixed bits wrong");

   a_data_write: assert property (@(posedge clk_sys) disable iff (reset)
      reg_wr && reg_addr == 16'hffdc
      |=> port9_output_data_q[4:0] == $past(reg_wdata[4:0]))
      else $error("output data write not stored");

   a_pin_reg_ro: assert property (@(posedge clk_sys) disable iff (reset)
      reg_wr && reg_addr == 16'hffdd
      |=> $stable(port9_output_data_q) &&
          $stable(port9_direction_control_q) &&
          $stable(converter_mode_register_q))
      else $error("write to port B register had an effect");

   a_amr_write: assert property (@(posedge clk_sys) disable iff (reset)
      reg_wr && reg_addr == 16'hffc4
      |=> converter_mode_register_q == $past(reg_wdata))
      else $error("converter mode write not stored");

   a_amr_read: assert property (@(posedge clk_sys) disable iff (reset)
      reg_rd && reg_addr == 16'hffc4
      |=> reg_rdata == $past(converter_mode_register_q))
      else $error("converter mode read wrong");

   a_sel_off: assert property (@(posedge clk_sys) disable iff (reset)
      !chan_on |=> analog_input_pin_sel == 8'h00)
      else $error("analog select set while channel off");

   a_sel_onehot: assert property (@(posedge clk_sys) disable iff (reset)
      chan_on |=> $onehot(analog_input_pin_sel))
      else $error("analog select not one-hot");

   a_sel_index: assert property (@(posedge clk_sys) disable iff (reset)
      chan_on |=> analog_input_pin_sel == (8'h01 << $past(chan[2:0])))
      else $error("analog select on wrong pin");

   a_portb_read: assert property (@(posedge clk_sys) disable iff (reset)
      reg_rd && reg_addr == 16'hffdd
      |=> reg_rdata == ($past(pb_sync_q) & ~analog_input_pin_sel))
      else $error("port B read not pin level");

   a_portb_sync: assert property (@(posedge clk_sys) disable iff (reset)
      pb_sync_q == $past(portb_pin_in, 2))
      else $error("port B sync depth wrong");

   a_p9_sync: assert property (@(posedge clk_sys) disable iff (reset)
      p9_sync_q == $past(port9_pin_in, 2))
      else $error("port nine sync depth wrong");

   a_output_read: assert property (@(posedge clk_sys) disable iff (reset)
      reg_rd && reg_addr == 16'hffdc && dir == 5'h1f
      |=> reg_rdata[4:0] == $past(port9_output_data_q[4:0]))
      else $error("output pin read not data");

   a_mixed_read: assert property (@(posedge clk_sys) disable iff (reset)
      reg_rd && reg_addr == 16'hffdc
      |=> reg_rdata[4:0] ==
          (($past(dir) & $past(port9_output_data_q[4:0])) |
           (~$past(dir) & $past(p9_sync_q))))
      else $error("port nine mixed read wrong");

   a_out_active: assert property (@(posedge clk_sys) disable iff (reset)
      power_mode == MODE_ACTIVE
      |=> port9_pin_out == $past(port9_output_data_q[4:0]))
      else $error("active drive value wrong");

   a_out_subactive: assert property (@(posedge clk_sys)
      disable iff (reset)
      power_mode == MODE_SUBACTIVE
      |=> port9_pin_out == $past(port9_output_data_q[4:0]))
      else $error("subactive drive value wrong");

   a_oe_subactive: assert property (@(posedge clk_sys) disable iff (reset)
      power_mode == MODE_SUBACTIVE |=> port9_pin_oe == $past(dir))
      else $error("subactive enable wrong");

   a_subsleep_hold: assert property (@(posedge clk_sys)
      disable iff (reset)
      power_mode == MODE_SUBSLEEP
      |=> $stable(port9_pin_out) && $stable(port9_pin_oe))
      else $error("port nine changed in subsleep");

   a_reset_clear: assert property (@(posedge clk_sys)
      reset
      |=> port9_pin_oe == 5'h00 && port9_pin_out == 5'h00 &&
          reg_rdata == 8'h00 && analog_input_pin_sel == 8'h00)
      else $error("outputs not cleared by reset");

   // Each pin gets its own check, so a swapped bit cannot hide.
   for (genvar i = 0; i < 5; i++) begin : g_pin_chk
      a_pin_drive: assert property (@(posedge clk_sys)
         disable iff (reset)
         power_mode == MODE_ACTIVE && dir[i]
         |=> port9_pin_oe[i] &&
             port9_pin_out[i] == $past(port9_output_data_q[i]))
         else $error("output pin not driven");

      a_pin_input: assert property (@(posedge clk_sys)
         disable iff (reset)
         power_mode == MODE_ACTIVE && !dir[i] |=> !port9_pin_oe[i])
         else $error("input pin driven");
   end

   for (genvar j = 0; j < 8; j++) begin : g_chan_chk
      a_pin_masked: assert property (@(posedge clk_sys)
         disable iff (reset)
         chan_on && chan[2:0] == 3'(j) && reg_rd && reg_addr == 16'hffdd
         |=> !reg_rdata[j])
         else $error("selected analog pin read as 1");
   end
endmodule : dual_port_pin_io

/* File: board_pins_model.sv */
// Board model for the port nine and port B pins.
`timescale 1ns/1ps
module board_pins_model (
   input wire logic [4:0] port9_pin_out,
   input wire logic [4:0] port9_pin_oe,
   input wire logic [4:0] ext9,
   input wire logic [7:0] extb,
   output logic [4:0] port9_pin_in,
   output logic [7:0] portb_pin_in
);
   // A driven pin shows the chip's value, so the board never fights it.
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         port9_pin_in[i] = port9_pin_oe[i] ? port9_pin_out[i] : ext9[i];
      end
   end
   // Port B is only sensed; the board alone sets its level.
   assign portb_pin_in = extb;
endmodule : board_pins_model

/* File: dual_port_pin_io_test.sv */
// Testbench for the dual port pin block.
`timescale 1ns/1ps
`include "dual_port_pin_io_defs.svh"
module dual_port_pin_io_test;
   import dual_port_pin_io_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   power_mode_t power_mode = MODE_ACTIVE;
   logic [4:0] ext9 = 5'h0a;
   logic [7:0] extb = 8'ha5;
   logic [4:0] port9_pin_in;
   logic [4:0] port9_pin_out;
   logic [4:0] port9_pin_oe;
   logic [7:0] portb_pin_in;
   logic [7:0] analog_input_pin_sel;
   int n_errors = 0;
   int tests_run = 0;
   always #2.5 clk_sys = ~clk_sys;
   dual_port_pin_io u_dut (.clk_sys, .reset, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .power_mode, .port9_pin_in,
      .port9_pin_out, .port9_pin_oe, .portb_pin_in, .analog_input_pin_sel);
   board_pins_model u_board (.port9_pin_out, .port9_pin_oe, .ext9,
      .extb, .port9_pin_in, .portb_pin_in);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
      @(posedge clk_sys);
      #1;
      chk(reg_rdata, 8'h00);
   endtask : rd
   // Pins land two edges after a write; settle a few more for the sync.
   task automatic oe_is(input logic [4:0] exp);
      repeat (3) @(posedge clk_sys);
      #1;
      chk({3'b000, port9_pin_oe}, {3'b000, exp});
   endtask : oe_is
   task automatic end_of_test;
      $display("errors=%0d checks=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   initial begin
      #20000;
      n_errors++;
      end_of_test;
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      oe_is(5'h00);
      rd(`OFS_PORT9_OUTPUT_DATA, 8'hca);
      wr(`OFS_PORT9_OUTPUT_DATA, 8'h35);
      wr(`OFS_PORT9_DIRECTION_CONTROL, 8'h05);
      @(posedge clk_sys);
      #1;
      chk({3'b000, port9_pin_oe}, 8'h05);
      chk({3'b000, port9_pin_out & port9_pin_oe}, 8'h05);
      repeat (3) @(posedge clk_sys);
      rd(`OFS_PORT9_OUTPUT_DATA, 8'hcf);
      rd(`OFS_PORT9_DIRECTION_CONTROL, 8'hff);
      rd(16'h0000, `UNMAPPED_READ_VALUE);
      wr(`OFS_PORTB_PIN_LEVELS, 8'h00);
      rd(`OFS_PORTB_PIN_LEVELS, 8'ha5);
      for (int k = 0; k < 8; k++) begin
         wr(`OFS_CONVERTER_MODE_REGISTER, 8'h08 | 8'(k));
         rd(`OFS_PORTB_PIN_LEVELS, 8'ha5 & ~(8'h01 << k));
         chk(analog_input_pin_sel, 8'h01 << k);
      end
      wr(`OFS_PORT9_DIRECTION_CONTROL, 8'h1f);
      oe_is(5'h1f);
      power_mode <= MODE_SLEEP;
      wr(`OFS_PORT9_DIRECTION_CONTROL, 8'h00);
      oe_is(5'h1f);
      power_mode <= MODE_STANDBY;
      oe_is(5'h00);
      power_mode <= MODE_ACTIVE;
      oe_is(5'h00);
      wr(`OFS_PORT9_DIRECTION_CONTROL, 8'h1f);
      oe_is(5'h1f);
      power_mode <= MODE_WATCH;
      wr(`OFS_PORT9_OUTPUT_DATA, 8'h0a);
      wr(`OFS_PORT9_DIRECTION_CONTROL, 8'h00);
      oe_is(5'h1f);
      chk({3'b000, port9_pin_out}, 8'h15);
      power_mode <= MODE_SUBACTIVE;
      oe_is(5'h00);
      chk({3'b000, port9_pin_out}, 8'h0a);
      power_mode <= MODE_SUBSLEEP;
      wr(`OFS_PORT9_DIRECTION_CONTROL, 8'h1f);
      oe_is(5'h00);
      power_mode <= MODE_ACTIVE;
      oe_is(5'h1f);
      rd(`OFS_PORT9_OUTPUT_DATA, 8'hca);
      reset <= 1'b1;
      oe_is(5'h00);
      reset <= 1'b0;
      oe_is(5'h00);
      wr(`OFS_PORT9_DIRECTION_CONTROL, 8'h1f);
      rd(`OFS_PORT9_OUTPUT_DATA, 8'hc0);
      end_of_test;
   end
endmodule : dual_port_pin_io_test
